// [rtl/ctrl_clk_pkg.sv]
/*
  Constants, register map and carrier types for the control subsystem
  clock and low-power block. Assumes one APB clock; every other clock is
  a one-cycle tick from outside or from a divider here.
*/
package ctrl_clk_pkg;
  localparam int DIV_W = 8;
  localparam logic [11:0] PLL_CONTROL_OFF = 12'h000;
  localparam logic [11:0] PLL_MULTIPLIER_OFF = 12'h004;
  localparam logic [11:0] PLL_STATE_OFF = 12'h008;
  localparam logic [11:0] SYSTEM_DIVIDER_OFF = 12'h00C;
  localparam logic [11:0] PLL_REQ_OFF = 12'h010;
  localparam logic [11:0] GATE0_OFF = 12'h014;
  localparam logic [11:0] GATE1_OFF = 12'h018;
  localparam logic [11:0] GATE3_OFF = 12'h01C;
  localparam logic [11:0] T2SEL_OFF = 12'h020;
  localparam logic [11:0] LSP_OFF = 12'h024;
  localparam logic [11:0] ACLK_OFF = 12'h028;
  localparam logic [11:0] HS_OFF = 12'h02C;
  localparam logic [11:0] STATUS_OFF = 12'h030;
  localparam logic [11:0] WAKESEL_OFF = 12'h034;
  localparam logic [11:0] NMICTL_OFF = 12'h038;
  localparam int PLL_REGS = 4;
  localparam int LPM_LSB = 0;
  localparam int QUAL_LSB = 2;
  localparam int GATE_LSB = 8;
  localparam int GATES = 24;
  localparam int T2_DIV_LSB = 2;
  localparam int BYPASS_BIT = 0;
  localparam logic [1:0] LPM_IDLE = 2'h0;
  localparam logic [1:0] LPM_STANDBY = 2'h1;
  localparam logic [1:0] T2_PERIPH = 2'h0;
  localparam logic [1:0] T2_CRYSTAL = 2'h1;
  localparam logic [1:0] T2_OSC = 2'h2;
  localparam logic [5:0] QUAL_BASE = 6'h02;
  localparam logic [7:0] MISS_LIMIT = 8'h08;
  localparam logic [31:0] GATE0_RST = 32'h00000000;
  localparam logic [31:0] ACLK_RST = 32'h00000000;
  localparam logic [31:0] LSP_RST = 32'h00000002;
  localparam logic [31:0] SYSDIV_RST = 32'h00000000;
  localparam int WAKE_PINS = 62;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_IDLE = 2'h1,
    MODE_STANDBY = 2'h3
  } lp_mode_t;

  typedef struct packed {
    logic pll_tick;
    logic crystal_tick;
    logic osc_tick;
    logic master_tick;
  } src_ticks_t;

  typedef struct packed {
    logic core;
    logic periph;
    logic input_clk;
    logic pll_system;
    logic timer2;
    logic low_speed;
    logic analog;
    logic shared_res;
    logic ext_port;
  } clk_en_t;
endpackage

// [rtl/ctrl_subsystem_clock_lpm.sv]
/*
  Control subsystem clocking, low-power modes, analog clock, shared clocks
  and missing-clock handling, with an APB register slave.
  Assumes all inputs synchronous to pclk and source clocks given as ticks.
*/
// Behaviour
// - Four PLL registers: master writes, control reads; request registers move write ownership.
// - Each peripheral clock enable is gated by its own gating register bit.
// - Core clock and peripheral clock are produced as two separate enables.
// - Normal runs both clocks, IDLE only peripheral, STANDBY none and ignores gating.
// - Timer 2 tick is a divided source chosen among peripheral, crystal, internal oscillator.
// - Programmable prescaler yields the low-speed serial peripheral clock.
// - Idle instruction strobe plus low-power select field picks IDLE or STANDBY.
// - IDLE stops core clock, keeps peripheral clock; enabled interrupt or NMI ends it.
// - Leaving IDLE restores core clock, raises wake interrupt if enabled, resumes in the same cycle.
// - STANDBY stops input, core and peripheral clocks.
// - STANDBY ends on selected one of 62 wake pins or INTERPROCESSOR_COMM interrupt 2.
// - Selected wake pin is qualified by the bits [7:2] value plus two samples before use.
// - Leaving STANDBY restores all clocks, raises wake interrupt if enabled, resumes.
// - Analog clock is system clock divided by control-only divider field.
// - Either analog subsystem reset returns analog clock control to default.
// - Analog clock stops while master is in deep sleep.
// - Shared resources run on system clock; external port on master clock.
// - System clock is PLL or crystal over divider; internal oscillator on failure.
// - Only main clock is watched; the watcher counts internal oscillator ticks.
// - Clock-fail goes at once to NMI units, PWM and system clock mux.
// - Clock-fail raises NMI and starts watchdog; overflow resets unless disabled.
module ctrl_subsystem_clock_lpm #(
  parameter logic [19:0] NMI_WD_LIMIT = 20'hFFFFF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ctrl_clk_pkg::src_ticks_t ticks,
  input wire logic master_pll_wr,
  input wire logic [1:0] master_pll_idx,
  input wire logic [31:0] master_pll_wdata,
  input wire logic master_pll_write_request,
  output logic [31:0] pll_control,
  output logic [31:0] pll_multiplier,
  output logic [31:0] pll_state,
  output logic [31:0] system_divider,
  output logic ctrl_owns_pll,
  input wire logic idle_status,
  input wire logic irq_pending,
  input wire logic nmi_in,
  input wire logic [ctrl_clk_pkg::WAKE_PINS-1:0] wake_pins,
  input wire logic ipc_wake_irq,
  input wire logic master_deep_sleep,
  input wire logic analog_bus_reset,
  input wire logic analog_soft_reset,
  output ctrl_clk_pkg::clk_en_t clk_en,
  output logic [ctrl_clk_pkg::GATES-1:0] periph_clk_en,
  output ctrl_clk_pkg::lp_mode_t mode,
  output logic wake_irq,
  output logic resume,
  output logic lowpower_handshake_status,
  output logic clock_fail_a,
  output logic ctrl_nmi,
  output logic device_reset_req
);
  typedef struct packed {
    ctrl_clk_pkg::lp_mode_t mode;
    logic [ctrl_clk_pkg::PLL_REGS-1:0][31:0] pll;
    logic owns;
    logic [31:0] gate0;
    logic [31:0] gate1;
    logic [31:0] gate3;
    logic [31:0] t2sel;
    logic [31:0] lsp;
    logic [31:0] aclk;
    logic hs;
    logic [5:0] wake_sel;
    logic [1:0] nmictl;
    logic [ctrl_clk_pkg::DIV_W-1:0] sys_cnt;
    logic [ctrl_clk_pkg::DIV_W-1:0] t2_cnt;
    logic [ctrl_clk_pkg::DIV_W-1:0] lsp_cnt;
    logic [ctrl_clk_pkg::DIV_W-1:0] a_cnt;
    logic [7:0] miss_cnt;
    logic fail;
    logic [6:0] qual_cnt;
    logic [19:0] wd_cnt;
    logic rst_req;
    logic wake;
    logic resume;
  } state_t;

  localparam int DW = ctrl_clk_pkg::DIV_W;

  state_t r;
  state_t next_r;

  // Divider count step: wraps to zero on the terminal count
  function automatic logic [DW-1:0] div_next(input logic [DW-1:0] cnt, input logic [DW-1:0] lim,
                                             input logic tick);
    if (!tick) begin
      div_next = cnt;
    end else if (cnt >= lim) begin
      div_next = '0;
    end else begin
      div_next = cnt + 1'b1;
    end
  endfunction

  function automatic logic div_hit(input logic [DW-1:0] cnt, input logic [DW-1:0] lim, input logic tick);
    div_hit = tick && (cnt >= lim);
  endfunction

  logic setup_wr;
  logic acc_wr;
  logic ok_addr;
  logic pll_addr;
  logic [1:0] pll_idx;
  logic ctrl_pll_denied;
  logic sys_src;
  logic sys_tick;
  logic periph_run;
  logic core_run;
  logic periph_tick;
  logic t2_src;
  logic wake_pin;
  logic wake_qualified;
  logic [1:0] lpm_sel;
  logic [6:0] qual_need;
  logic [DW-1:0] sys_div;
  logic [DW-1:0] t2_div;
  logic [DW-1:0] lsp_div;
  logic [DW-1:0] aclk_div;
  logic idle_exit;
  logic standby_exit;

  assign setup_wr = psel && penable && pwrite;
  assign acc_wr = setup_wr;
  assign pll_addr = (paddr[11:4] == 8'h00) && (paddr[1:0] == 2'h0);
  assign pll_idx = paddr[3:2];
  assign ctrl_pll_denied = pll_addr && !r.owns;

  // Divider limits; every divider divides by its field plus one
  assign sys_div = r.pll[3][DW-1:0];
  assign t2_div = r.t2sel[ctrl_clk_pkg::T2_DIV_LSB +: DW];
  assign lsp_div = r.lsp[DW-1:0];
  assign aclk_div = r.aclk[DW-1:0];
  // Seven bits, so the widest qualification field cannot wrap to a short count
  assign qual_need = 7'(r.gate0[ctrl_clk_pkg::QUAL_LSB +: 6]) + 7'(ctrl_clk_pkg::QUAL_BASE);
  // Clock fail also ends IDLE so the NMI handler gets a running core
  assign idle_exit = irq_pending || nmi_in || r.fail;
  assign standby_exit = wake_qualified || ipc_wake_irq;

  always_comb begin
    unique case (paddr)
      ctrl_clk_pkg::PLL_CONTROL_OFF, ctrl_clk_pkg::PLL_MULTIPLIER_OFF, ctrl_clk_pkg::PLL_STATE_OFF,
      ctrl_clk_pkg::SYSTEM_DIVIDER_OFF, ctrl_clk_pkg::PLL_REQ_OFF, ctrl_clk_pkg::GATE0_OFF,
      ctrl_clk_pkg::GATE1_OFF, ctrl_clk_pkg::GATE3_OFF, ctrl_clk_pkg::T2SEL_OFF, ctrl_clk_pkg::LSP_OFF,
      ctrl_clk_pkg::ACLK_OFF, ctrl_clk_pkg::HS_OFF, ctrl_clk_pkg::STATUS_OFF, ctrl_clk_pkg::WAKESEL_OFF,
      ctrl_clk_pkg::NMICTL_OFF: ok_addr = 1'b1;
      default: ok_addr = 1'b0;
    endcase
  end

  // Zero-wait slave; denied PLL writes and holes answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && (!ok_addr || (pwrite && ctrl_pll_denied));

  always_comb begin
    prdata = 32'h00000000;
    if (psel && !pwrite) begin
      unique case (paddr)
        ctrl_clk_pkg::PLL_CONTROL_OFF, ctrl_clk_pkg::PLL_MULTIPLIER_OFF, ctrl_clk_pkg::PLL_STATE_OFF,
        ctrl_clk_pkg::SYSTEM_DIVIDER_OFF: prdata = r.pll[pll_idx];
        ctrl_clk_pkg::PLL_REQ_OFF: prdata = {31'h0, r.owns};
        ctrl_clk_pkg::GATE0_OFF: prdata = r.gate0;
        ctrl_clk_pkg::GATE1_OFF: prdata = r.gate1;
        ctrl_clk_pkg::GATE3_OFF: prdata = r.gate3;
        ctrl_clk_pkg::T2SEL_OFF: prdata = r.t2sel;
        ctrl_clk_pkg::LSP_OFF: prdata = r.lsp;
        ctrl_clk_pkg::ACLK_OFF: prdata = r.aclk;
        ctrl_clk_pkg::HS_OFF: prdata = {31'h0, r.hs};
        ctrl_clk_pkg::STATUS_OFF: prdata = {26'h0, r.rst_req, r.fail, r.owns, 1'b0, r.mode};
        ctrl_clk_pkg::WAKESEL_OFF: prdata = {26'h0, r.wake_sel};
        ctrl_clk_pkg::NMICTL_OFF: prdata = {30'h0, r.nmictl};
        default: prdata = 32'h00000000;
      endcase
    end
  end

  // System clock source: oscillator takes over once the main clock is lost
  always_comb begin
    if (r.fail) begin
      sys_src = ticks.osc_tick;
    end else if (!r.pll[0][ctrl_clk_pkg::BYPASS_BIT]) begin
      sys_src = ticks.crystal_tick;
    end else begin
      sys_src = ticks.pll_tick;
    end
  end

  // Deep sleep removes the input clock to the control side except timer 2 on crystal or oscillator and the master-clocked external port
  assign sys_tick = div_hit(r.sys_cnt, sys_div, sys_src) && !master_deep_sleep;
  assign periph_run = (r.mode != ctrl_clk_pkg::MODE_STANDBY);
  assign core_run = (r.mode == ctrl_clk_pkg::MODE_NORMAL);
  assign periph_tick = sys_tick && periph_run;

  always_comb begin
    unique case (r.t2sel[1:0])
      ctrl_clk_pkg::T2_CRYSTAL: t2_src = ticks.crystal_tick && periph_run;
      ctrl_clk_pkg::T2_OSC: t2_src = ticks.osc_tick && periph_run;
      default: t2_src = periph_tick;
    endcase
  end

  assign wake_pin = wake_pins[r.wake_sel];
  assign wake_qualified = (r.qual_cnt >= qual_need);
  assign lpm_sel = r.gate0[ctrl_clk_pkg::LPM_LSB +: 2];

  always_comb begin
    clk_en = '0;
    clk_en.input_clk = sys_tick && periph_run;
    clk_en.pll_system = sys_tick;
    clk_en.core = sys_tick && core_run;
    clk_en.periph = periph_tick;
    clk_en.timer2 = div_hit(r.t2_cnt, t2_div, t2_src);
    clk_en.low_speed = div_hit(r.lsp_cnt, lsp_div, periph_tick);
    clk_en.analog = div_hit(r.a_cnt, aclk_div, sys_tick) && !master_deep_sleep;
    clk_en.shared_res = sys_tick;
    clk_en.ext_port = ticks.master_tick;
  end

  // Gating applies only while the peripheral clock runs at all
  assign periph_clk_en = {ctrl_clk_pkg::GATES{periph_tick}} & r.gate0[31:ctrl_clk_pkg::GATE_LSB];

  always_comb begin
    next_r = r;
    next_r.wake = 1'b0;
    next_r.resume = 1'b0;

    // Master side writes while it holds ownership
    if (master_pll_wr && !r.owns) begin
      next_r.pll[master_pll_idx] = master_pll_wdata;
    end
    if (master_pll_write_request) begin
      next_r.owns = 1'b0;
    end

    if (acc_wr) begin
      unique case (paddr)
        ctrl_clk_pkg::PLL_CONTROL_OFF, ctrl_clk_pkg::PLL_MULTIPLIER_OFF, ctrl_clk_pkg::PLL_STATE_OFF,
        ctrl_clk_pkg::SYSTEM_DIVIDER_OFF: begin
          if (r.owns) begin
            next_r.pll[pll_idx] = pwdata;
          end
        end
        // Set wins over a master reclaim in the same cycle
        ctrl_clk_pkg::PLL_REQ_OFF: begin
          if (pwdata[0]) begin
            next_r.owns = 1'b1;
          end
        end
        ctrl_clk_pkg::GATE0_OFF: next_r.gate0 = pwdata;
        ctrl_clk_pkg::GATE1_OFF: next_r.gate1 = pwdata;
        ctrl_clk_pkg::GATE3_OFF: next_r.gate3 = pwdata;
        ctrl_clk_pkg::T2SEL_OFF: next_r.t2sel = pwdata;
        ctrl_clk_pkg::LSP_OFF: next_r.lsp = pwdata;
        ctrl_clk_pkg::ACLK_OFF: next_r.aclk = pwdata;
        ctrl_clk_pkg::HS_OFF: next_r.hs = pwdata[0];
        ctrl_clk_pkg::WAKESEL_OFF: begin
          if (pwdata[5:0] < 6'(ctrl_clk_pkg::WAKE_PINS)) begin
            next_r.wake_sel = pwdata[5:0];
          end
        end
        ctrl_clk_pkg::NMICTL_OFF: next_r.nmictl = pwdata[1:0];
        default: next_r.gate1 = r.gate1;
      endcase
    end

    // Analog resets override any software value
    if (analog_bus_reset || analog_soft_reset) begin
      next_r.aclk = ctrl_clk_pkg::ACLK_RST;
      next_r.a_cnt = '0;
    end else begin
      next_r.a_cnt = div_next(r.a_cnt, aclk_div, sys_tick && !master_deep_sleep);
    end

    next_r.sys_cnt = div_next(r.sys_cnt, sys_div, sys_src && !master_deep_sleep);
    next_r.t2_cnt = div_next(r.t2_cnt, t2_div, t2_src);
    next_r.lsp_cnt = div_next(r.lsp_cnt, lsp_div, periph_tick);

    // Watcher lives on oscillator ticks so it survives a dead crystal
    if (ticks.crystal_tick) begin
      next_r.miss_cnt = '0;
    end else if (ticks.osc_tick && !r.fail) begin
      next_r.miss_cnt = r.miss_cnt + 8'h01;
    end
    if (r.miss_cnt >= ctrl_clk_pkg::MISS_LIMIT) begin
      next_r.fail = 1'b1;
    end

    // Watchdog runs from the fail until software disables it
    if (r.fail && !r.nmictl[0] && !r.rst_req) begin
      if (r.wd_cnt >= NMI_WD_LIMIT) begin
        next_r.rst_req = 1'b1;
      end else begin
        next_r.wd_cnt = r.wd_cnt + 20'h00001;
      end
    end

    // Qualifier samples on oscillator ticks; standby has no peripheral clock
    if (!wake_pin) begin
      next_r.qual_cnt = '0;
    end else if (ticks.osc_tick && r.qual_cnt != 7'h7F) begin
      next_r.qual_cnt = r.qual_cnt + 7'h01;
    end

    unique case (r.mode)
      ctrl_clk_pkg::MODE_NORMAL: begin
        if (idle_status) begin
          if (lpm_sel == ctrl_clk_pkg::LPM_STANDBY) begin
            next_r.mode = ctrl_clk_pkg::MODE_STANDBY;
          end else begin
            next_r.mode = ctrl_clk_pkg::MODE_IDLE;
          end
        end
      end
      ctrl_clk_pkg::MODE_IDLE: begin
        if (idle_exit) begin
          next_r.mode = ctrl_clk_pkg::MODE_NORMAL;
          next_r.wake = r.gate1[0];
          next_r.resume = 1'b1;
        end
      end
      ctrl_clk_pkg::MODE_STANDBY: begin
        if (standby_exit) begin
          next_r.mode = ctrl_clk_pkg::MODE_NORMAL;
          next_r.wake = r.gate1[0];
          next_r.resume = 1'b1;
        end
      end
      default: next_r.mode = ctrl_clk_pkg::MODE_NORMAL;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.mode <= ctrl_clk_pkg::MODE_NORMAL;
      r.pll[3] <= ctrl_clk_pkg::SYSDIV_RST;
      r.gate0 <= ctrl_clk_pkg::GATE0_RST;
      r.lsp <= ctrl_clk_pkg::LSP_RST;
      r.aclk <= ctrl_clk_pkg::ACLK_RST;
    end else begin
      r <= next_r;
    end
  end

  assign pll_control = r.pll[0];
  assign pll_multiplier = r.pll[1];
  assign pll_state = r.pll[2];
  assign system_divider = r.pll[3];
  assign ctrl_owns_pll = r.owns;
  assign mode = r.mode;
  assign wake_irq = r.wake;
  assign resume = r.resume;
  assign lowpower_handshake_status = r.hs;
  assign clock_fail_a = r.fail;
  assign ctrl_nmi = r.fail;
  assign device_reset_req = r.rst_req;
endmodule

// [dv/ctrl_clk_assertions.sv]
/* Checker for the clock and low-power block.
   Assumes it is bound to the top module. */
module ctrl_clk_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pslverr,
  input wire logic ctrl_owns_pll,
  input wire logic idle_status,
  input wire logic irq_pending,
  input wire logic ipc_wake_irq,
  input wire logic master_deep_sleep,
  input wire ctrl_clk_pkg::clk_en_t clk_en,
  input wire logic [ctrl_clk_pkg::GATES-1:0] periph_clk_en,
  input wire ctrl_clk_pkg::lp_mode_t mode,
  input wire logic resume,
  input wire logic clock_fail_a,
  input wire logic ctrl_nmi
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  pll_deny_a: assert property (psel && penable && pwrite && paddr < 12'h010 && !ctrl_owns_pll |-> pslverr)
    else $error("pll write not refused");
  gate_periph_a: assert property (|periph_clk_en |-> clk_en.periph)
    else $error("gate without periph clock");
  idle_core_a: assert property (mode == ctrl_clk_pkg::MODE_IDLE |-> !clk_en.core)
    else $error("core clock in idle");
  standby_off_a: assert property (mode == ctrl_clk_pkg::MODE_STANDBY |->
    !(clk_en.core || clk_en.periph || clk_en.input_clk || |periph_clk_en))
    else $error("clock in standby");
  idle_enter_a: assert property (mode == ctrl_clk_pkg::MODE_NORMAL && idle_status && !clock_fail_a
    |=> mode != ctrl_clk_pkg::MODE_NORMAL)
    else $error("idle not entered");
  idle_exit_a: assert property (mode == ctrl_clk_pkg::MODE_IDLE && irq_pending
    |=> mode == ctrl_clk_pkg::MODE_NORMAL && resume ##1 !resume)
    else $error("idle exit wrong");
  ipc_exit_a: assert property (mode == ctrl_clk_pkg::MODE_STANDBY && ipc_wake_irq
    |=> mode == ctrl_clk_pkg::MODE_NORMAL && resume)
    else $error("standby exit wrong");
  analog_stop_a: assert property (master_deep_sleep && $past(master_deep_sleep) |-> !clk_en.analog)
    else $error("analog clock in deep sleep");
  fail_nmi_a: assert property (clock_fail_a |-> ctrl_nmi ##1 clock_fail_a)
    else $error("clock fail not held");
  c_idle: cover property (mode == ctrl_clk_pkg::MODE_IDLE ##1 resume);
  c_wake: cover property (mode == ctrl_clk_pkg::MODE_STANDBY ##1 resume);
  c_fail: cover property ($rose(clock_fail_a));
endmodule

bind ctrl_subsystem_clock_lpm ctrl_clk_assertions chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pslverr,
  .ctrl_owns_pll, .idle_status, .irq_pending, .ipc_wake_irq, .master_deep_sleep, .clk_en, .periph_clk_en, .mode,
  .resume, .clock_fail_a, .ctrl_nmi);

// [dv/master_side_model.sv]
/* Master-side model: PLL writes, ownership reclaim, deep sleep and wake.
   Assumes the bench calls its tasks right after a rising edge. */
module master_side_model (
  input wire logic pclk,
  input wire logic handshake,
  input wire ctrl_clk_pkg::lp_mode_t mode,
  output logic wr = 0,
  output logic [1:0] idx = '0,
  output logic [31:0] wdata = '0,
  output logic reclaim = 0,
  output logic deep_sleep = 0,
  output logic ipc_irq = 0
);
  task automatic pll_write(input logic [1:0] i, input logic [31:0] d);
    wr <= 1;
    idx <= i;
    wdata <= d;
    @(posedge pclk);
    wr <= 0;
    wdata <= ~d;
    @(posedge pclk);
  endtask
  task automatic give_back();
    reclaim <= 1;
    @(posedge pclk);
    reclaim <= 0;
    @(posedge pclk);
  endtask
  // Sleep once standby is reported (or after 100 cycles), or the control side loses clocks unprepared
  task automatic sleep_wake();
    for (int n = 0; n < 100 && !(handshake && mode == ctrl_clk_pkg::MODE_STANDBY); n++) @(posedge pclk);
    deep_sleep <= 1;
    repeat (20) @(posedge pclk);
    deep_sleep <= 0;
    ipc_irq <= 1;
    @(posedge pclk);
    ipc_irq <= 0;
    @(posedge pclk);
  endtask
endmodule

// [dv/test_ctrl_subsystem_clock_lpm.sv]
/* Bench for the clock and low-power block.
   Assumes the master-side model and the bound checker. */
module test_ctrl_subsystem_clock_lpm;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err, xtal_on = 1;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, v, pll_multiplier, master_pll_wdata;
  ctrl_clk_pkg::src_ticks_t ticks = '0;
  logic idle_status = 0, irq_pending = 0, nmi_in = 0, ipc_wake_irq, master_deep_sleep, analog_bus_reset = 0;
  logic analog_soft_reset = 0, ctrl_owns_pll, lowpower_handshake_status, clock_fail_a, ctrl_nmi, device_reset_req;
  logic master_pll_wr, master_pll_write_request, wake_irq, resume;
  logic [1:0] master_pll_idx;
  logic [ctrl_clk_pkg::WAKE_PINS-1:0] wake_pins = '0;
  logic [ctrl_clk_pkg::GATES-1:0] periph_clk_en, orm;
  ctrl_clk_pkg::clk_en_t clk_en;
  ctrl_clk_pkg::lp_mode_t mode;
  int errors = 0, checks_done = 0, cyc = 0, nres = 0, nwk = 0, n, d, p, r0, w0;
  int k[7];
  ctrl_subsystem_clock_lpm #(.NMI_WD_LIMIT(20'h00010)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ticks, .master_pll_wr, .master_pll_idx, .master_pll_wdata,
    .master_pll_write_request, .pll_control(), .pll_multiplier, .pll_state(), .system_divider(), .ctrl_owns_pll,
    .idle_status, .irq_pending, .nmi_in, .wake_pins, .ipc_wake_irq, .master_deep_sleep, .analog_bus_reset,
    .analog_soft_reset, .clk_en, .periph_clk_en, .mode, .wake_irq, .resume, .lowpower_handshake_status,
    .clock_fail_a, .ctrl_nmi, .device_reset_req);
  master_side_model ms (.pclk, .handshake(lowpower_handshake_status), .mode, .wr(master_pll_wr),
    .idx(master_pll_idx), .wdata(master_pll_wdata), .reclaim(master_pll_write_request),
    .deep_sleep(master_deep_sleep), .ipc_irq(ipc_wake_irq));
  task automatic summarize();
    if (errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    pwdata <= ~wd;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, '0);
    chk(rd, e);
  endtask
  task automatic measure(input int c);
    k = '{default: 0};
    orm = '0;
    repeat (c) begin
      @(negedge pclk);
      k[0] += clk_en.core;
      k[1] += clk_en.periph;
      k[2] += clk_en.low_speed;
      k[3] += clk_en.analog;
      k[4] += clk_en.pll_system;
      k[5] += clk_en.timer2;
      k[6] += clk_en.ext_port;
      orm |= periph_clk_en;
    end
    @(posedge pclk);
  endtask
  task automatic sleep(input logic [31:0] g);
    apb(1, ctrl_clk_pkg::GATE0_OFF, g);
    idle_status <= 1;
    @(posedge pclk);
    idle_status <= 0;
    r0 = nres;
    w0 = nwk;
    measure(12);
  endtask
  // Source ticks and the hang limit share one counter
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    ticks <= {cyc[0], xtal_on && cyc % 3 == 0, cyc[1:0] == 2'h0, cyc[0]};
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end
  always @(negedge pclk) begin
    nres += (resume === 1'b1);
    nwk += (wake_irq === 1'b1);
  end
  initial begin
    forever #2 pclk = ~pclk;
  end
  initial begin
    v = $urandom(65662);
    repeat (12) @(posedge pclk);
    presetn <= 1;
    rdchk(ctrl_clk_pkg::SYSTEM_DIVIDER_OFF, ctrl_clk_pkg::SYSDIV_RST);
    rdchk(ctrl_clk_pkg::LSP_OFF, ctrl_clk_pkg::LSP_RST);
    rdchk(ctrl_clk_pkg::ACLK_OFF, ctrl_clk_pkg::ACLK_RST);
    rdchk(12'h03C, '0);
    chk(err, 1);
    v = $urandom;
    apb(1, ctrl_clk_pkg::PLL_MULTIPLIER_OFF, v);
    chk(err, 1);
    ms.pll_write(2'h1, v);
    chk(pll_multiplier, v);
    apb(1, ctrl_clk_pkg::PLL_REQ_OFF, 1);
    apb(1, ctrl_clk_pkg::PLL_MULTIPLIER_OFF, ~v);
    chk(pll_multiplier, ~v);
    ms.give_back();
    chk(ctrl_owns_pll, 0);
    apb(1, ctrl_clk_pkg::GATE1_OFF, 1);
    d = ctrl_clk_pkg::LSP_RST[7:0] + 1;
    for (int code = 0; code < 4; code++) begin
      v = $urandom & 32'hFFFFFF00;
      apb(1, ctrl_clk_pkg::GATE0_OFF, v);
      measure(48);
      chk({orm, 8'h00}, v);
      chk(k[0] > 0 && k[1] > 0 && k[2] >= k[1] / d - 1 && k[2] <= k[1] / d + 1, 1);
      apb(1, ctrl_clk_pkg::HS_OFF, code == 1);
      sleep(v | code);
      chk(mode, code == 1 ? ctrl_clk_pkg::MODE_STANDBY : ctrl_clk_pkg::MODE_IDLE);
      chk({k[0] == 0, k[1] > 0}, {1'b1, code != 1});
      if (code == 1) begin
        ms.sleep_wake();
      end else begin
        irq_pending <= code != 3;
        nmi_in <= code == 3;
        @(posedge pclk);
        {irq_pending, nmi_in} <= 2'b00;
        @(posedge pclk);
      end
      chk({mode, 2'(nres - r0), 2'(nwk - w0)}, {ctrl_clk_pkg::MODE_NORMAL, 2'd1, 2'd1});
    end
    d = $urandom % 4;
    p = $urandom % 62;
    apb(1, ctrl_clk_pkg::WAKESEL_OFF, p);
    sleep(d << 2 | 1);
    wake_pins[p] <= 1;
    repeat ((d + 1) * 4) @(posedge pclk);
    chk(mode, ctrl_clk_pkg::MODE_STANDBY);
    for (n = 0; n < 40 && mode !== ctrl_clk_pkg::MODE_NORMAL; n++) @(posedge pclk);
    chk(mode, ctrl_clk_pkg::MODE_NORMAL);
    wake_pins <= '0;
    for (int i = 0; i < 2; i++) begin
      d = 1 + $urandom % 3;
      apb(1, ctrl_clk_pkg::ACLK_OFF, d);
      measure(96);
      chk(k[3] >= k[4] / (d + 1) - 1 && k[3] <= k[4] / (d + 1) + 1, 1);
      analog_bus_reset <= i == 0;
      analog_soft_reset <= i == 1;
      @(posedge pclk);
      {analog_bus_reset, analog_soft_reset} <= 2'b00;
      rdchk(ctrl_clk_pkg::ACLK_OFF, ctrl_clk_pkg::ACLK_RST);
    end
    // Oscillator ticks come every fourth cycle, master ticks every second one
    d = $urandom % 4;
    apb(1, ctrl_clk_pkg::T2SEL_OFF, d << ctrl_clk_pkg::T2_DIV_LSB | 32'(ctrl_clk_pkg::T2_OSC));
    measure(96);
    chk(k[5] >= 24 / (d + 1) - 1 && k[5] <= 24 / (d + 1) + 1, 1);
    chk(k[6], 48);
    // Watchdog held off first, so the fail and the reset request are seen apart
    apb(1, ctrl_clk_pkg::NMICTL_OFF, 1);
    xtal_on <= 0;
    for (n = 0; n < 200 && clock_fail_a !== 1'b1; n++) @(posedge pclk);
    chk(ctrl_nmi, 1);
    measure(60);
    chk({k[4] > 0, device_reset_req}, 2'b10);
    apb(1, ctrl_clk_pkg::NMICTL_OFF, 0);
    for (n = 0; n < 100 && device_reset_req !== 1'b1; n++) @(posedge pclk);
    rdchk(ctrl_clk_pkg::STATUS_OFF, 32'h00000030);
    summarize();
  end
endmodule
